/* File: epb_pkg.sv */
`default_nettype none
// Shared constants of the Ethernet packet buffer block.
package epb_pkg;
  // Bus geometry.
  localparam int AW = 10;
  localparam int DW = 32;
  // Buffer geometry: 64 entries, pointers carry one wrap bit.
  localparam int DEPTH = 64;
  localparam int PW = 7;
  localparam logic [PW-1:0] FULL_FILL = 7'h40;
  localparam logic [PW-1:0] PSF_THRESH = 7'h10;
  // Register byte addresses.
  localparam logic [AW-1:0] OFS_CTRL = 10'h000;
  localparam logic [AW-1:0] OFS_STAT = 10'h004;
  localparam logic [AW-1:0] OFS_MASK = 10'h008;
  localparam logic [AW-1:0] OFS_FILL = 10'h00C;
  localparam logic [AW-1:0] OFS_RXST = 10'h010;
  localparam logic [AW-1:0] OFS_JABBER = 10'h18C;
  // Control bit positions.
  localparam int CB_GO = 0;
  localparam int CB_FULLSF = 1;
  localparam int CB_FDX = 2;
  localparam int CB_LARGE = 3;
  localparam int CB_RXFSF = 4;
  localparam int NCTRL = 5;
  localparam logic [NCTRL-1:0] CTRL_RST = 5'h02;
  // Status and mask bit positions.
  localparam int SB_AHBERR = 0;
  localparam int SB_TOOBIG = 1;
  localparam int SB_UNDER = 2;
  localparam int SB_RETRY = 3;
  localparam int SB_RXDROP = 4;
  localparam int NSTAT = 5;
  localparam logic [NSTAT-1:0] STAT_RST = 5'h00;
  // Frame figures.
  localparam logic [4:0] MAX_TRIES = 5'h10;
  localparam logic [13:0] JAB_LEN = 14'd1518;
  localparam logic [13:0] JAB_LEN_BIG = 14'd1536;
  localparam logic [9:0] JAB_MAX = 10'h3FF;
  // Transmit read-side states.
  typedef enum logic [1:0] {
    EPB_TX_IDLE = 2'b00,
    EPB_TX_SEND = 2'b01,
    EPB_TX_SKIP = 2'b10
  } epb_tx_state_t;
endpackage : epb_pkg
`default_nettype wire

/* File: epb_top.sv */
// Implementation choice: the Avalon-MM interface to the registers.
`default_nettype none
module epb_top (
  // Clock and reset.
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Avalon-MM register slave.
  input  wire logic [epb_pkg::AW-1:0]   avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [epb_pkg::DW-1:0]   avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [epb_pkg::DW-1:0]        avs_readdata,
  output logic                          avs_waitrequest,
  output logic                          irq,
  // Transmit fetch side from system memory.
  output logic                          fetch_req,
  input  wire logic                     fetch_valid,
  input  wire logic [7:0]               fetch_data,
  input  wire logic                     fetch_last,
  input  wire logic                     fetch_err,
  // Transmit side toward the MAC transmitter.
  output logic                          tx_start,
  input  wire logic                     tx_rd,
  output logic [7:0]                    tx_data,
  output logic                          tx_last,
  input  wire logic                     tx_done,
  input  wire logic                     tx_fail,
  // Receive side from the MAC receiver.
  input  wire logic                     rx_push,
  input  wire logic [7:0]               rx_data,
  input  wire logic                     rx_eof,
  input  wire logic [13:0]              rx_len,
  input  wire logic                     rx_crc_err,
  input  wire logic                     rx_align_err,
  input  wire logic                     rx_sym_err,
  // Receive side toward the DMA.
  output logic                          rxo_valid,
  output logic [7:0]                    rxo_data,
  output logic                          rxo_last,
  input  wire logic                     rxo_ready
);
  import epb_pkg::*;

  // Occupancy between two wrapping pointers.
  function automatic logic [PW-1:0] fill(input logic [PW-1:0] a,
                                         input logic [PW-1:0] b);
    fill = a - b;
  endfunction : fill

  // Entry index of a wrapping pointer.
  function automatic logic [PW-2:0] idx(input logic [PW-1:0] p);
    idx = p[PW-2:0];
  endfunction : idx

  // Buffer memories; bit 8 marks a frame's last byte.
  logic [8:0] tx_mem [DEPTH];
  logic [8:0] rx_mem [DEPTH];

  // Software-visible state.
  logic [NCTRL-1:0] ctrl;         // Mode bits; go bit reads zero.
  logic [NSTAT-1:0] status;       // Sticky events.
  logic [NSTAT-1:0] mask;         // Interrupt enables.
  logic [9:0]       jabber_frame_count; // Saturating count.
  logic [14:0]      rx_hold;      // Drop flag and length of last frame.

  // Transmit pointers and control.
  logic [PW-1:0] wr;              // Next write.
  logic [PW-1:0] wfs;             // Start of frame being fetched.
  logic [PW-1:0] fs;              // Oldest retained byte.
  logic [PW-1:0] rd;              // Next byte to the MAC.
  logic [PW-1:0] frames;          // Complete frames held.
  logic [4:0]    tries;           // Failed attempts of head frame.
  logic          tx_run;          // Transmission enabled.
  logic          dma_halt;        // Fetch halted by an oversize frame.
  logic          err_pend;        // Bus error waiting for its turn.
  epb_tx_state_t st;

  // Receive pointers.
  logic [PW-1:0] rwr, rwfs, rrd;
  logic          rx_ovf;          // Current frame overran the buffer.

  // Bus decode.
  wire bus_req    = avs_read | avs_write;
  wire bus_take   = bus_req & ~avs_waitrequest;
  wire wr_lane0   = bus_take & avs_write & avs_byteenable[0];
  wire w_ctrl     = wr_lane0 & (avs_address == OFS_CTRL);
  wire w_stat     = wr_lane0 & (avs_address == OFS_STAT);
  wire w_mask     = wr_lane0 & (avs_address == OFS_MASK);
  wire go_write   = w_ctrl & avs_writedata[CB_GO];
  wire full_sf    = ctrl[CB_FULLSF];
  wire fdx        = ctrl[CB_FDX];
  // Retain the frame for retry unless cut-through full duplex.
  wire retain     = full_sf | ~fdx;

  // Transmit event decode.
  wire fetch_take = fetch_req & fetch_valid;
  wire tx_empty   = (rd == wr);
  wire in_send    = (st == EPB_TX_SEND);
  wire underflow  = in_send & tx_rd & tx_empty & ~full_sf;
  wire too_big    = fetch_take & ~fetch_err & ~fetch_last & full_sf
                    & (fill(wr, wfs) == FULL_FILL - 7'h01);
  wire frame_in   = fetch_take & ~fetch_err & fetch_last;
  wire ahb_report = err_pend & (frames == 7'h00);
  wire last_fail  = in_send & tx_fail & (tries == MAX_TRIES - 5'h01);
  wire skip_end   = (st == EPB_TX_SKIP) & ~tx_empty & tx_mem[idx(rd)][8];
  // A frame whose last byte was already popped when the final attempt
  // failed has nothing left to skip, so it is dropped at once.
  wire drop_now   = last_fail & tx_last;
  wire frame_out  = (in_send & tx_done) | skip_end | drop_now;
  wire start_ok   = tx_run & ((frames != 7'h00)
                    | (~full_sf & (fill(wr, rd) >= PSF_THRESH)));

  // Receive event decode.
  wire rx_full    = (fill(rwr, rrd) == FULL_FILL);
  wire rx_bad     = rx_crc_err | rx_align_err | rx_sym_err;
  wire rx_drop    = rx_push & rx_eof & (rx_bad | rx_ovf | rx_full);
  wire [13:0] jab_lim = ctrl[CB_LARGE] ? JAB_LEN_BIG : JAB_LEN;
  wire jab_hit    = rx_push & rx_eof & rx_bad & (rx_len > jab_lim);
  wire rxo_load   = (~rxo_valid | rxo_ready) & (rrd != rwfs);

  // Status set terms, set beats a same-cycle clear.
  wire [NSTAT-1:0] st_set = {rx_drop, last_fail, underflow, too_big,
                             ahb_report};
  wire [NSTAT-1:0] next_status =
    (status & ~(w_stat ? avs_writedata[NSTAT-1:0] : STAT_RST)) | st_set;

  // Read data selection; unmapped addresses read zero.
  wire [DW-1:0] rd_mux =
    (avs_address == OFS_CTRL)   ? {27'h0000000, ctrl & ~5'h01} :
    (avs_address == OFS_STAT)   ? {27'h0000000, status} :
    (avs_address == OFS_MASK)   ? {27'h0000000, mask} :
    (avs_address == OFS_FILL)   ? {14'h0000, tx_run, dma_halt,
                                   1'b0, fill(rwr, rrd),
                                   1'b0, fill(wr, fs)} :
    (avs_address == OFS_RXST)   ? {17'h00000, rx_hold} :
    (avs_address == OFS_JABBER) ? {22'h000000, jabber_frame_count} :
    32'h00000000;

  // Bus answer: waitrequest drops one cycle after a request is seen,
  // so every access takes two edges; read data stands with it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Control, mask, status and interrupt registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl   <= CTRL_RST;
      mask   <= STAT_RST;
      status <= STAT_RST;
      irq    <= 1'b0;
    end else begin
      if (w_ctrl) begin
        ctrl <= avs_writedata[NCTRL-1:0];
      end
      if (w_mask) begin
        mask <= avs_writedata[NSTAT-1:0];
      end
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

  // Fetch request is dropped one entry early because it is registered;
  // a grant in the same cycle can still find room.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= ~dma_halt & ~err_pend & ~go_write & ~underflow
                   & (fill(wr, fs) < FULL_FILL - 7'h01);
    end
  end

  // Transmit buffer writes.
  always_ff @(posedge mclk) begin
    if (fetch_take & ~fetch_err) begin
      tx_mem[idx(wr)] <= {fetch_last, fetch_data};
    end
  end

  // Transmit pointers, frame count and state. An underflow flushes
  // everything, so it overrides every other pointer move.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr <= 7'h00; wfs <= 7'h00; fs <= 7'h00; rd <= 7'h00;
      frames   <= 7'h00;
      tries    <= 5'h00;
      tx_run   <= 1'b0;
      dma_halt <= 1'b0;
      err_pend <= 1'b0;
      st       <= EPB_TX_IDLE;
      tx_start <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
    end else if (underflow) begin
      wr <= 7'h00; wfs <= 7'h00; fs <= 7'h00; rd <= 7'h00;
      frames   <= 7'h00;
      tx_run   <= go_write;
      st       <= EPB_TX_IDLE;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (go_write) begin
        tx_run   <= 1'b1;
        dma_halt <= 1'b0;
      end
      if (ahb_report) begin
        err_pend <= 1'b0;
      end
      // Write side: drop the partial frame on a bus error.
      if (fetch_take & fetch_err) begin
        wr       <= wfs;
        err_pend <= 1'b1;
      end else if (too_big) begin
        wr       <= wfs;
        dma_halt <= 1'b1;
      end else if (fetch_take) begin
        wr <= wr + 7'h01;
        if (fetch_last) begin
          wfs <= wr + 7'h01;
        end
      end
      frames <= frames + {6'h00, frame_in} - {6'h00, frame_out};
      // Read side.
      unique case (st)
        EPB_TX_IDLE: begin
          if (start_ok) begin
            tx_start <= 1'b1;
            tx_last  <= 1'b0;
            tries    <= 5'h00;
            st       <= EPB_TX_SEND;
          end
        end
        EPB_TX_SEND: begin
          if (tx_done) begin
            fs <= rd;
            st <= EPB_TX_IDLE;
          end else if (last_fail) begin
            // The last flag is cleared on every start, so it is only
            // set here when this attempt really reached the frame end.
            if (tx_last) begin
              fs <= rd;
              st <= EPB_TX_IDLE;
            end else begin
              st <= EPB_TX_SKIP;
            end
          end else if (tx_fail & retain) begin
            rd       <= fs;
            tries    <= tries + 5'h01;
            tx_start <= 1'b1;
            tx_last  <= 1'b0;
          end else if (tx_rd & ~tx_empty) begin
            tx_data <= tx_mem[idx(rd)][7:0];
            tx_last <= tx_mem[idx(rd)][8];
            rd      <= rd + 7'h01;
            if (~retain) begin
              fs <= rd + 7'h01;
            end
          end
        end
        EPB_TX_SKIP: begin
          if (~tx_empty) begin
            rd <= rd + 7'h01;
            if (skip_end) begin
              fs <= rd + 7'h01;
              st <= EPB_TX_IDLE;
            end
          end
        end
        default: st <= EPB_TX_IDLE;
      endcase
    end
  end

  // Receive buffer writes: each accepted push is one entry.
  always_ff @(posedge mclk) begin
    if (rx_push & ~rx_full) begin
      rx_mem[idx(rwr)] <= {rx_eof, rx_data};
    end
  end

  // Receive pointers. A frame is committed to the DMA only at its end;
  // an errored or overrun frame rewinds to its start with its last byte, which
  // frees its space for the next frame.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rwr    <= 7'h00;
      rwfs   <= 7'h00;
      rx_ovf <= 1'b0;
    end else if (rx_push) begin
      if (rx_eof) begin
        rx_ovf <= 1'b0;
        if (rx_drop) begin
          rwr <= rwfs;
        end else begin
          rwr  <= rwr + 7'h01;
          rwfs <= rwr + 7'h01;
        end
      end else if (rx_full) begin
        rx_ovf <= 1'b1;
      end else begin
        rwr <= rwr + 7'h01;
      end
    end
  end

  // Frame-end status hold and jabber statistics, for every frame.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_hold            <= 15'h0000;
      jabber_frame_count <= 10'h000;
    end else begin
      if (rx_push & rx_eof) begin
        rx_hold <= {rx_drop, rx_len};
      end
      if (jab_hit & (jabber_frame_count != JAB_MAX)) begin
        jabber_frame_count <= jabber_frame_count + 10'h001;
      end
    end
  end

  // Receive readout toward the DMA.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rrd       <= 7'h00;
      rxo_valid <= 1'b0;
      rxo_data  <= 8'h00;
      rxo_last  <= 1'b0;
    end else if (rxo_load) begin
      rxo_valid <= 1'b1;
      rxo_data  <= rx_mem[idx(rrd)][7:0];
      rxo_last  <= rx_mem[idx(rrd)][8];
      rrd       <= rrd + 7'h01;
    end else if (rxo_ready) begin
      rxo_valid <= 1'b0;
    end
  end

  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_fail_pre;
    in_send & tx_fail & retain & ~underflow;
  endsequence

  chk_fetch_space: assert property (
    fetch_take |-> fill(wr, fs) < FULL_FILL)
    else $error("fetch granted with no buffer space");
  chk_full_start: assert property (
    tx_start & full_sf |-> $past(frames) != 7'h00)
    else $error("full mode start without a whole frame");
  chk_under_flush: assert property (
    underflow |=> (wr == 7'h00) && (frames == 7'h00))
    else $error("underflow did not flush the buffer");
  chk_no_restart: assert property (
    ~tx_run & ~go_write |=> ~tx_run)
    else $error("transmission resumed without a go write");
  chk_retry_rewind: assert property (
    s_fail_pre ##0 (tries != MAX_TRIES - 5'h01) |=> rd == $past(fs))
    else $error("retry did not rewind to the buffered frame");
  chk_retry_limit: assert property (
    s_fail_pre ##0 last_fail |=> (st != EPB_TX_SEND) ##0 status[SB_RETRY])
    else $error("sixteenth failure did not flush the frame");
  chk_err_order: assert property (
    err_pend & (frames != 7'h00) |=> ~$rose(status[SB_AHBERR]))
    else $error("bus error reported ahead of good frames");
  chk_jabber_count: assert property (
    jab_hit & (jabber_frame_count != JAB_MAX)
    |=> jabber_frame_count == $past(jabber_frame_count) + 10'h001)
    else $error("jabber frame not counted");
  chk_jabber_hold: assert property (
    jabber_frame_count == JAB_MAX |=> jabber_frame_count == JAB_MAX)
    else $error("jabber counter wrapped");
  chk_rx_drop: assert property (
    rx_drop |=> rwr == $past(rwfs) ##0 rwfs == $past(rwfs))
    else $error("errored receive frame kept its space");
endmodule : epb_top
`default_nettype wire

/* File: epb_far.sv */
`default_nettype none
// Far side: a memory source that feeds fetch bytes, and a MAC that pops them.
module epb_far (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst,
  // Fetch side.
  input  wire logic       fetch_req,
  output logic            fetch_valid,
  output logic [7:0]      fetch_data,
  output logic            fetch_last,
  output logic            fetch_err,
  // MAC transmitter side.
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_rd = 1'b0,
  output logic            tx_done = 1'b0,
  output logic            tx_fail = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int   len = 0;      // Bytes still to hand over.
  int   gap = 0;      // Idle cycles after each byte, to starve the buffer.
  int   hold = 0;     // Idle cycles left.
  int   sent = 0;     // Bytes taken by the buffer.
  int   fails = 0;    // Attempts still to be failed.
  int   starts = 0;   // Start pulses seen.
  int   at_start = 0; // Bytes sent when the last start came.
  int   popped = 0;   // Bytes popped in the current attempt.
  int   err_at = -1;  // Byte number that meets a bus error.
  logic busy = 1'b0;  // An attempt is running.
  logic rd_d = 1'b0;  // A pop was made last cycle.
  // A released data line shows the inverse, so a stale byte never matches.
  assign fetch_valid = (len > 0) && (hold == 0);
  assign fetch_data  = fetch_valid ? sent[7:0] : ~sent[7:0];
  assign fetch_last  = (len == 1);
  assign fetch_err   = fetch_valid && (sent == err_at);
  // Queue n more bytes off the clock edge, so no count update is lost.
  task automatic load(input int n, input int g, input int fl);
    @(negedge mclk);
    len   += n;
    gap   = g;
    fails = fl;
  endtask : load
  // Source: a byte stays put until the buffer takes it.
  always @(posedge mclk) begin
    hold <= (hold > 0) ? hold - 1 : 0;
    if (fetch_req && fetch_valid) begin
      len  <= len - 1;
      sent <= sent + 1;
      hold <= gap;
    end
  end
  // MAC: one pop every third cycle, then ends the attempt at the last byte.
  always @(posedge mclk) begin
    rd_d    <= tx_rd;
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
    tx_rd   <= busy && !tx_rd && !rd_d && !tx_start && !rst;
    if (rst) begin
      busy <= 1'b0;
    end else if (tx_start) begin
      busy     <= 1'b1;
      popped   <= 0;
      starts   <= starts + 1;
      at_start <= sent;
    end else if (rd_d && busy) begin
      popped <= popped + 1;
      if (tx_last) begin
        busy    <= 1'b0;
        tx_fail <= (fails > 0);
        tx_done <= (fails == 0);
        fails   <= (fails > 0) ? fails - 1 : 0;
      end
    end
  end
endmodule : epb_far
`default_nettype wire

/* File: epb_top_tb.sv */
`default_nettype none
// Register-level bench for the packet buffer, with the far-side model.
module epb_top_tb;
  import epb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] avs_address = '0;
  logic          avs_read = 1'b0, avs_write = 1'b0;
  logic [DW-1:0] avs_writedata = '0, avs_readdata;
  logic          avs_waitrequest, irq, fetch_req, fetch_valid, fetch_last;
  logic [7:0]    fetch_data, tx_data, rxo_data;
  logic          tx_start, tx_rd, tx_last, tx_done, tx_fail, fetch_err;
  logic          rx_push = 1'b0, rx_eof = 1'b0;
  logic [7:0]    rx_data = '0;
  logic [13:0]   rx_len = '0;
  logic          rx_crc_err = 1'b0, rx_align_err = 1'b0, rx_sym_err = 1'b0;
  logic          rxo_valid, rxo_last;
  int            mismatches = 0, checks_done = 0, rx_got = 0;
  // Clock at 25 MHz.
  initial begin
    forever #20 mclk = ~mclk;
  end
  epb_top i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .fetch_last(fetch_last), .fetch_err(fetch_err),
    .tx_start(tx_start), .tx_rd(tx_rd), .tx_data(tx_data),
    .tx_last(tx_last), .tx_done(tx_done), .tx_fail(tx_fail),
    .rx_push(rx_push), .rx_data(rx_data), .rx_eof(rx_eof), .rx_len(rx_len),
    .rx_crc_err(rx_crc_err), .rx_align_err(rx_align_err),
    .rx_sym_err(rx_sym_err), .rxo_valid(rxo_valid), .rxo_data(rxo_data),
    .rxo_last(rxo_last), .rxo_ready(1'b1));
  epb_far f (.mclk(mclk), .rst(rst), .fetch_req(fetch_req),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .fetch_last(fetch_last), .fetch_err(fetch_err),
    .tx_start(tx_start), .tx_data(tx_data),
    .tx_last(tx_last), .tx_rd(tx_rd), .tx_done(tx_done), .tx_fail(tx_fail));
  // Forwarded receive bytes.
  always @(posedge mclk) begin
    if (rxo_valid === 1'b1) rx_got <= rx_got + 1;
  end
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  `define CHK(g, e) check(g, e)
  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, output logic [DW-1:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) mismatches++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] q;
    bus(1'b0, a, '0, q);
    `CHK(q, e);
  endtask : rdc
  // Reads a register until bit b is set, with a bound on the tries.
  task automatic poll(input logic [AW-1:0] a, input int b,
                      output logic [DW-1:0] q);
    for (int i = 0; i < 200; i++) begin
      bus(1'b0, a, '0, q);
      if (q[b] === 1'b1) break;
    end
  endtask : poll
  // Waits until k starts were seen and the MAC is idle again.
  task automatic wait_tx(input int k);
    for (int i = 0; i < 4000; i++) begin
      @(posedge mclk);
      if (f.starts >= k && !f.busy) break;
    end
  endtask : wait_tx
  // Pushes one received frame; the error flags come with the last byte.
  task automatic rx_frame(input int n, input logic [13:0] l,
                          input logic [2:0] e);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_push <= 1'b1;
      rx_data <= i[7:0];
      rx_eof  <= (i == n - 1);
      rx_len  <= l;
      {rx_crc_err, rx_align_err, rx_sym_err} <= (i == n - 1) ? e : 3'h0;
    end
    @(posedge mclk);
    rx_push <= 1'b0;
    rx_eof  <= 1'b0;
  endtask : rx_frame
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
  endtask : reset_dut
  // Watchdog, well beyond the length of the sequence.
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [DW-1:0] q;
    logic [13:0]   ln [7] = '{1519, 1518, 1519, 1600, 1600, 1536, 1537};
    logic [2:0]    er [7] = '{3'h4, 3'h4, 3'h0, 3'h2, 3'h1, 3'h4, 3'h4};
    logic          lg [7] = '{0, 0, 0, 0, 0, 1, 1};
    int            exp;
    exp = 0;
    reset_dut();
    rdc(OFS_CTRL, {27'h0, CTRL_RST});
    rdc(OFS_STAT, 32'h0);
    rdc(OFS_JABBER, 32'h0);
    rdc(10'h040, 32'h0);
    wr(OFS_MASK, 32'h0);
    // Whole frame must be held before the start pulse.
    f.load(20, 0, 0);
    wr(OFS_CTRL, 32'h03);
    wait_tx(1);
    `CHK(f.at_start, 20);
    `CHK(f.popped, 20);
    rdc(OFS_FILL, 32'h20000);
    // Two collisions are retried from the held copy, not refetched.
    f.load(20, 0, 2);
    wait_tx(4);
    `CHK(f.sent, 40);
    `CHK(f.popped, 20);
    // The sixteenth failure drops the frame and raises a status bit.
    f.load(20, 0, 16);
    wait_tx(20);
    rdc(OFS_STAT, 32'h08);
    rdc(OFS_FILL, 32'h20000);
    `CHK(irq, 1'b0);
    wr(OFS_MASK, 32'h08);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1);
    wr(OFS_STAT, 32'h08);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0);
    // Receive: the jabber count follows length, error and the large limit.
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CTRL, lg[i] ? 32'h0A : 32'h02);
      rx_frame(4, ln[i], er[i]);
      exp += (er[i] != 0 && ln[i] > (lg[i] ? 1536 : 1518));
      rdc(OFS_JABBER, exp);
    end
    `CHK(rx_got, 4);
    rdc(OFS_STAT, 32'h10);
    // The count stops at its top value.
    for (int i = 0; i < 1030; i++) rx_frame(1, 14'd2000, 3'h4);
    rdc(OFS_JABBER, 32'h3FF);
    // Partial mode: start at the threshold, then a slow source underflows.
    wr(OFS_CTRL, 32'h01);
    f.load(40, 8, 0);
    poll(OFS_STAT, SB_UNDER, q);
    `CHK(f.at_start, 60 + PSF_THRESH);
    `CHK(q, 32'h14);
    f.load(20, 0, 0);
    poll(OFS_FILL, 4, q);
    `CHK(q[17], 1'b0);
    `CHK(f.starts, 21);
    wr(OFS_CTRL, 32'h01);
    wait_tx(22);
    `CHK(f.starts, 22);
    // A frame larger than the buffer halts the fetch in full mode.
    reset_dut();
    wr(OFS_CTRL, 32'h03);
    f.load(DEPTH + 6, 0, 0);
    poll(OFS_STAT, SB_TOOBIG, q);
    `CHK(q, 32'h02);
    bus(1'b0, OFS_FILL, '0, q);
    `CHK(q[16], 1'b1);
    // A bus error behind a buffered good frame is reported after it.
    reset_dut();
    wr(OFS_CTRL, 32'h03);
    repeat (8) @(posedge mclk);
    f.err_at = f.sent + 4;
    f.load(5, 0, 0);
    poll(OFS_STAT, SB_AHBERR, q);
    `CHK(q, 32'h01);
    `CHK(f.popped, 6);
    report_and_stop();
  end
endmodule : epb_top_tb
`default_nettype wire
